// File: hw/ivl_cfg.svh
`ifndef IVL_CFG_SVH
`define IVL_CFG_SVH

// control register bit positions
`define IVL_CTL_RBIF      0
`define IVL_CTL_INTF      1
`define IVL_CTL_T0IF      2
`define IVL_CTL_RBIE      3
`define IVL_CTL_INTE      4
`define IVL_CTL_T0IE      5
`define IVL_CTL_PEIE      6
`define IVL_CTL_GLOBAL_EN 7
`define IVL_CTL_RESET     8'h00
`define IVL_PFLAG_RESET   8'h00
`define IVL_PEN_RESET     8'h00
`define IVL_VECTOR        13'h0004
// instruction clock cycles per machine cycle
`define IVL_CYC_CLKS      2'h3
// pin synchroniser depth yields the three-to-four cycle latency
`define IVL_SYNC_STAGES   3

`endif

// File: hw/ivl_pkg.sv
package ivl_pkg;
    typedef logic [12:0] ivl_pc_t;
    typedef struct packed {
        logic    load;
        ivl_pc_t addr;
    } ivl_pc_load_s;
    typedef struct packed {
        logic [7:0] data;
        logic       ctl;
        logic       pflag1;
        logic       pflag2;
        logic       pen1;
        logic       pen2;
    } ivl_wr_s;
    typedef enum logic [1:0] {
        IVL_RUN,
        IVL_SLEEP,
        IVL_ISR
    } ivl_state_e;
endpackage

// File: hw/ivl_irq_vector.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivl_cfg.svh"

module ivl_irq_vector (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  extIrqPin,
    input  wire logic                  portChangeEvt,
    input  wire logic                  timerZeroOvf,
    input  wire logic [7:0]            periphEvt1,
    input  wire logic [7:0]            periphEvt2,
    input  wire ivl_pkg::ivl_wr_s      regWrite,
    input  wire logic                  sleepOp,
    input  wire logic                  returnFromIrqOp,
    input  wire logic                  cycleEnd,
    input  wire ivl_pkg::ivl_pc_t      nextProgramCounter,
    input  wire ivl_pkg::ivl_pc_t      stackTop,
    output logic [7:0]                 irqControlReg,
    output logic [7:0]                 periphFlagReg1,
    output logic [7:0]                 periphFlagReg2,
    output logic [7:0]                 periphEnableReg1,
    output logic [7:0]                 periphEnableReg2,
    output ivl_pkg::ivl_pc_load_s      pcLoad,
    output logic                       stackPush,
    output ivl_pkg::ivl_pc_t           pushAddr,
    output logic                       irqRequest,
    output logic                       sleeping
);
    // pin synchroniser: a rise counts once stages 2 and 3 agree
    logic [`IVL_SYNC_STAGES-1:0] pinSync_reg;
    logic                        pinStable_reg;
    logic [7:0]                  ctl_reg;
    logic [7:0]                  ctl_next;
    logic [7:0]                  pf1_reg;
    logic [7:0]                  pf2_reg;
    logic [7:0]                  pe1_reg;
    logic [7:0]                  pe2_reg;
    ivl_pkg::ivl_state_e         state_reg;
    ivl_pkg::ivl_state_e         state_next;
    ivl_pkg::ivl_pc_load_s       pcLoad_next;
    logic                        push_next;

    function automatic logic [7:0] holdFlags(input logic [7:0] cur, input logic [7:0] evt,
                                             input logic wr, input logic [7:0] wdata);
        // set wins over a simultaneous software clear
        holdFlags = (wr ? wdata : cur) | evt;
    endfunction

    wire agree      = pinSync_reg[1] == pinSync_reg[2];
    wire pinRise    = agree && pinSync_reg[1] && !pinStable_reg;
    wire [7:0] ctlEvt = {5'h00, timerZeroOvf, pinRise, portChangeEvt};
    wire periphAny  = |(pf1_reg & pe1_reg) | |(pf2_reg & pe2_reg);
    wire periphReq  = ctl_reg[`IVL_CTL_PEIE] && periphAny;
    wire localReq   = (ctl_reg[`IVL_CTL_T0IF] && ctl_reg[`IVL_CTL_T0IE])
                    | (ctl_reg[`IVL_CTL_INTF] && ctl_reg[`IVL_CTL_INTE])
                    | (ctl_reg[`IVL_CTL_RBIF] && ctl_reg[`IVL_CTL_RBIE]);
    wire anyEnabled = localReq | periphReq;
    wire take       = ctl_reg[`IVL_CTL_GLOBAL_EN] && anyEnabled;
    // taken at a cycle boundary so one- and two-cycle instructions see the same latency
    wire takeNow    = take && cycleEnd && state_reg != ivl_pkg::IVL_ISR;
    wire wakeNow    = state_reg == ivl_pkg::IVL_SLEEP && anyEnabled;
    // a wake that vectors is an accepted interrupt too, so it drops the enable
    wire wakeVector = wakeNow && ctl_reg[`IVL_CTL_GLOBAL_EN];

    always_comb begin
        ctl_next = holdFlags(ctl_reg, ctlEvt, regWrite.ctl, regWrite.data);
        if (returnFromIrqOp) begin
            ctl_next[`IVL_CTL_GLOBAL_EN] = 1'b1;
        end
        // return wins over a take in the same cycle, matching the sequencer
        if ((takeNow && !returnFromIrqOp) || wakeVector) begin
            ctl_next[`IVL_CTL_GLOBAL_EN] = 1'b0;
        end
    end

    always_comb begin
        state_next  = state_reg;
        pcLoad_next = '{load: 1'b0, addr: nextProgramCounter};
        push_next   = 1'b0;
        case (state_reg)
            ivl_pkg::IVL_RUN, ivl_pkg::IVL_ISR: begin
                if (returnFromIrqOp) begin
                    pcLoad_next = '{load: 1'b1, addr: stackTop};
                    state_next  = ivl_pkg::IVL_RUN;
                end else if (takeNow) begin
                    pcLoad_next = '{load: 1'b1, addr: `IVL_VECTOR};
                    push_next   = 1'b1;
                    state_next  = ivl_pkg::IVL_ISR;
                end else if (sleepOp && state_reg == ivl_pkg::IVL_RUN) begin
                    state_next  = ivl_pkg::IVL_SLEEP;
                end
            end
            ivl_pkg::IVL_SLEEP: begin
                if (wakeNow) begin
                    if (ctl_reg[`IVL_CTL_GLOBAL_EN]) begin
                        pcLoad_next = '{load: 1'b1, addr: `IVL_VECTOR};
                        push_next   = 1'b1;
                        state_next  = ivl_pkg::IVL_ISR;
                    end else begin
                        pcLoad_next = '{load: 1'b1, addr: nextProgramCounter};
                        state_next  = ivl_pkg::IVL_RUN;
                    end
                end
            end
            default: state_next = ivl_pkg::IVL_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pinSync_reg   <= '0;
            pinStable_reg <= 1'b0;
        end else begin
            pinSync_reg   <= {pinSync_reg[1:0], extIrqPin};
            if (agree) begin
                pinStable_reg <= pinSync_reg[1];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_reg <= `IVL_CTL_RESET;
            pf1_reg <= `IVL_PFLAG_RESET;
            pf2_reg <= `IVL_PFLAG_RESET;
            pe1_reg <= `IVL_PEN_RESET;
            pe2_reg <= `IVL_PEN_RESET;
        end else begin
            ctl_reg <= ctl_next;
            pf1_reg <= holdFlags(pf1_reg, periphEvt1, regWrite.pflag1, regWrite.data);
            pf2_reg <= holdFlags(pf2_reg, periphEvt2, regWrite.pflag2, regWrite.data);
            pe1_reg <= regWrite.pen1 ? regWrite.data : pe1_reg;
            pe2_reg <= regWrite.pen2 ? regWrite.data : pe2_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg  <= ivl_pkg::IVL_RUN;
            pcLoad     <= '0;
            stackPush  <= 1'b0;
            pushAddr   <= '0;
            irqRequest <= 1'b0;
            sleeping   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            pcLoad     <= pcLoad_next;
            stackPush  <= push_next;
            pushAddr   <= nextProgramCounter;
            irqRequest <= take;
            sleeping   <= state_next == ivl_pkg::IVL_SLEEP;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqControlReg    <= `IVL_CTL_RESET;
            periphFlagReg1   <= `IVL_PFLAG_RESET;
            periphFlagReg2   <= `IVL_PFLAG_RESET;
            periphEnableReg1 <= `IVL_PEN_RESET;
            periphEnableReg2 <= `IVL_PEN_RESET;
        end else begin
            irqControlReg    <= ctl_next;
            periphFlagReg1   <= holdFlags(pf1_reg, periphEvt1, regWrite.pflag1, regWrite.data);
            periphFlagReg2   <= holdFlags(pf2_reg, periphEvt2, regWrite.pflag2, regWrite.data);
            periphEnableReg1 <= regWrite.pen1 ? regWrite.data : pe1_reg;
            periphEnableReg2 <= regWrite.pen2 ? regWrite.data : pe2_reg;
        end
    end
endmodule

`default_nettype wire

// File: tb/ivl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ivl_core_model (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  sleeping,
    input  wire ivl_pkg::ivl_pc_load_s pcLoad,
    input  wire logic                  stackPush,
    input  wire ivl_pkg::ivl_pc_t      pushAddr,
    output ivl_pkg::ivl_pc_t           nextProgramCounter,
    output ivl_pkg::ivl_pc_t           stackTop,
    output logic                       cycleEnd
);
    // boundary on every other clock, frozen in sleep, so takes wait zero or one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            nextProgramCounter <= 13'h0001;
            stackTop           <= 13'h1fff;
            cycleEnd           <= 1'h0;
        end else begin
            cycleEnd <= ~cycleEnd & ~sleeping;
            if (pcLoad.load) nextProgramCounter <= pcLoad.addr + 13'h0001;
            else if (cycleEnd) nextProgramCounter <= nextProgramCounter + 13'h0001;
            if (stackPush) stackTop <= pushAddr;
        end
    end
endmodule
`default_nettype wire

// File: tb/ivl_irq_vector_props.sv
`timescale 1ns/1ps
`default_nettype none
module ivl_irq_vector_props (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  portChangeEvt,
    input wire logic [7:0]            periphEvt1,
    input wire logic                  returnFromIrqOp,
    input wire ivl_pkg::ivl_pc_t      stackTop,
    input wire ivl_pkg::ivl_wr_s      regWrite,
    input wire logic [7:0]            irqControlReg,
    input wire logic [7:0]            periphFlagReg1,
    input wire ivl_pkg::ivl_pc_load_s pcLoad,
    input wire logic                  stackPush,
    input wire logic                  irqRequest
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_flag; portChangeEvt |=> irqControlReg[0]; endproperty
    a_flag: assert property (p_flag) else $error("port flag lost");
    property p_pf; |periphEvt1 |=> &(periphFlagReg1 | ~$past(periphEvt1)); endproperty
    a_pf: assert property (p_pf) else $error("periph flag lost");
    property p_hold; irqControlReg[0] && !regWrite.ctl |=> irqControlReg[0]; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_req; &{irqControlReg[7], irqControlReg[4], irqControlReg[1]} |=> irqRequest; endproperty
    a_req: assert property (p_req) else $error("no request");
    property p_gate; stackPush |-> $past(irqControlReg[7]); endproperty
    a_gate: assert property (p_gate) else $error("take without enable");
    property p_take; stackPush |-> pcLoad.load && pcLoad.addr == 13'h0004 && !irqControlReg[7]; endproperty
    a_take: assert property (p_take) else $error("bad take");
    property p_ret; returnFromIrqOp |=> pcLoad.addr == $past(stackTop) && irqControlReg[7]; endproperty
    a_ret: assert property (p_ret) else $error("bad return");
    property p_rst; $fell(rst) |-> irqControlReg == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("enable survives reset");
endmodule
bind ivl_irq_vector ivl_irq_vector_props i_props (.mclk, .rst, .portChangeEvt, .periphEvt1,
    .returnFromIrqOp, .stackTop, .regWrite, .irqControlReg, .periphFlagReg1, .pcLoad,
    .stackPush, .irqRequest);
`default_nettype wire

// File: tb/test_ivl_irq_vector.sv
`timescale 1ns/1ps
`default_nettype none
module test_ivl_irq_vector;
    logic                  mclk = 1'h0;
    logic                  rst = 1'h1;
    logic                  extIrqPin = 1'h0;
    logic                  portChangeEvt = 1'h0;
    logic                  timerZeroOvf = 1'h0;
    logic                  sleepOp = 1'h0;
    logic                  returnFromIrqOp = 1'h0;
    logic [7:0]            periphEvt1 = 8'h00;
    logic [7:0]            periphEvt2 = 8'h00;
    logic [7:0]            periphFlagReg2, periphEnableReg1, periphEnableReg2;
    ivl_pkg::ivl_wr_s      regWrite = '0;
    ivl_pkg::ivl_pc_t      nextProgramCounter, stackTop, pushAddr, retAddr;
    ivl_pkg::ivl_pc_load_s pcLoad;
    logic [7:0]            irqControlReg, periphFlagReg1;
    logic                  cycleEnd, stackPush, irqRequest, sleeping;
    logic [17:0]           rows [3] = '{{2'h2, 8'h00, 8'h01}, {2'h1, 8'h00, 8'h04}, {2'h0, 8'ha5, 8'h00}};
    int                    errors = 0;
    int                    checked = 0;
    int                    n;
    ivl_irq_vector i_ivl_irq_vector (.mclk, .rst, .extIrqPin, .portChangeEvt, .timerZeroOvf,
        .periphEvt1, .periphEvt2, .regWrite, .sleepOp, .returnFromIrqOp, .cycleEnd,
        .nextProgramCounter, .stackTop, .irqControlReg, .periphFlagReg1, .periphFlagReg2,
        .periphEnableReg1, .periphEnableReg2, .pcLoad, .stackPush, .pushAddr, .irqRequest,
        .sleeping);
    ivl_core_model i_ivl_core_model (.mclk, .rst, .sleeping, .pcLoad, .stackPush, .pushAddr,
        .nextProgramCounter, .stackTop, .cycleEnd);
    task automatic end_sim;
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [4:0] sel, input logic [7:0] d);
        regWrite = {d, sel};
        step(1);
        regWrite = '0;
    endtask
    task automatic waitLoad(output int k);
        k = 0;
        while (pcLoad.load !== 1'h1 && k < 12) begin
            step(1);
            k++;
        end
    endtask
    initial forever #5 mclk = ~mclk;
    // whole run is well under a hundred cycles
    initial begin
        #50000;
        errors++;
        end_sim;
    end
    initial begin
        step(16);
        rst = 1'h0;
        foreach (rows[i]) begin
            wr(5'h18, 8'h00);
            {portChangeEvt, timerZeroOvf, periphEvt1} = rows[i][17:8];
            step(1);
            {portChangeEvt, timerZeroOvf, periphEvt1} = '0;
            cmp(irqControlReg, rows[i][7:0]);
            cmp(periphFlagReg1, rows[i][15:8]);
        end
        // clear and event on one edge: the event must win
        portChangeEvt = 1'h1;
        wr(5'h10, 8'h00);
        portChangeEvt = 1'h0;
        cmp(irqControlReg, 8'h01);
        wr(5'h10, 8'h90);
        extIrqPin = 1'h1;
        waitLoad(n);
        cmp(n inside {[3:7]}, 1'h1);
        cmp({stackPush, pcLoad.addr}, {1'h1, 13'h0004});
        cmp(irqControlReg, 8'h12);
        wr(5'h10, 8'h10);
        retAddr = stackTop;
        returnFromIrqOp = 1'h1;
        step(1);
        returnFromIrqOp = 1'h0;
        cmp({pcLoad.load, pcLoad.addr}, {1'h1, retAddr});
        step(4);
        cmp(irqControlReg, 8'h90);
        for (int g = 0; g < 2; g++) begin
            wr(5'h10, {g[0], 7'h08});
            sleepOp = 1'h1;
            step(1);
            sleepOp = 1'h0;
            cmp(sleeping, 1'h1);
            portChangeEvt = 1'h1;
            step(1);
            portChangeEvt = 1'h0;
            // boundary counter is frozen from here, so the return address holds
            retAddr = nextProgramCounter;
            waitLoad(n);
            cmp({stackPush, pcLoad.addr}, g ? {1'h1, 13'h0004} : {1'h0, retAddr});
            cmp(irqControlReg[0], 1'h1);
        end
        wr(5'h10, 8'h80);
        wr(5'h02, 8'h01);
        cmp(periphEnableReg1, 8'h01);
        wr(5'h01, 8'h02);
        cmp(periphEnableReg2, 8'h02);
        periphEvt2 = 8'h02;
        step(1);
        periphEvt2 = 8'h00;
        cmp(periphFlagReg2, 8'h02);
        step(1);
        cmp(irqRequest, 1'h0);
        wr(5'h10, 8'hc0);
        step(1);
        cmp(irqRequest, 1'h1);
        wr(5'h10, 8'h80);
        rst = 1'h1;
        step(1);
        rst = 1'h0;
        cmp(irqControlReg, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
